/* File: core/bsbe_addr_gen.sv */
/*
  data-memory address generator for the bit-set path.
  assumes index base is a valid 12-bit pointer supplied by the core.
*/
`timescale 1ns/1ps
`default_nettype none
`include "bsbe_consts.svh"
module bsbe_addr_gen (
  input wire logic [7:0] reg_addr, // register operand
  input wire logic bank_bit, // bank operand
  input wire logic ext_set_en, // extended instruction set on
  input wire logic [3:0] bank_selector_reg, // bank select contents
  input wire logic [11:0] index_base, // pointer for indexed literal offset
  output logic [11:0] mem_addr, // resolved data address
  output bsbe_pkg::bsbe_amode_t amode // chosen addressing mode
);
  // mode choice and address forming
  always_comb begin
    if (!bank_bit && ext_set_en && reg_addr <= `BSBE_IDX_LIMIT) begin
      amode = bsbe_pkg::BSBE_MODE_INDEXED;
      mem_addr = index_base + {4'h0, reg_addr};
    end else if (!bank_bit) begin
      amode = bsbe_pkg::BSBE_MODE_ACCESS;
      // access addresses up to 5f map to bank 0, 60 and above to the sfr bank (f)
      mem_addr = (reg_addr <= `BSBE_ACC_LOW_LIMIT) ? {4'h0, reg_addr} : {`BSBE_ACC_HIGH_BANK, reg_addr};
    end else begin
      amode = bsbe_pkg::BSBE_MODE_BANKED;
      mem_addr = {bank_selector_reg, reg_addr};
    end
  end
endmodule : bsbe_addr_gen
`default_nettype wire

/* File: core/bsbe_consts.svh */
/*
  constants for the bit-set and relative-jump executor: opcode fields, phase codes, address map.
  assumes inclusion by bare name from the core files.
*/
`ifndef BSBE_CONSTS_SVH
`define BSBE_CONSTS_SVH
`define BSBE_OPC_SET_BIT 4'h8
`define BSBE_OPC_JUMP 5'h1a
`define BSBE_OPC_HI 15
`define BSBE_OPC_LO 12
`define BSBE_JOPC_LO 11
`define BSBE_BIT_HI 11
`define BSBE_BIT_LO 9
`define BSBE_BANK_BIT 8
`define BSBE_OFS_HI 10
`define BSBE_IDX_LIMIT 8'h5f
`define BSBE_ACC_LOW_LIMIT 8'h5f
`define BSBE_ACC_HIGH_BANK 4'hf
`define BSBE_PC_RESET 21'h000000
`define BSBE_PH_Q1 2'h0
`define BSBE_PH_Q2 2'h1
`define BSBE_PH_Q3 2'h2
`define BSBE_PH_Q4 2'h3
`endif

/* File: core/bsbe_exec.sv */
/*
  executor for the single-bit set and unconditional relative jump of an 8-bit core.
  assumes instr/instr_valid come from the decode stage, phase counts q1..q4 synchronous to clk_sys,
  and data memory answers rd_data combinationally for the address driven in q2.
*/
`timescale 1ns/1ps
`default_nettype none
`include "bsbe_consts.svh"
module bsbe_exec (
  input wire logic clk_sys, // core clock
  input wire logic reset_n, // async reset, low active
  input wire logic [1:0] phase, // q1..q4 phase code
  input wire logic [15:0] instr, // fetched instruction word
  input wire logic instr_valid, // instr present at q1
  input wire logic ext_set_en, // extended instruction set
  input wire logic [3:0] bank_selector_reg, // bank select contents
  input wire logic [11:0] index_base, // indexed mode base pointer
  input wire logic [20:0] pc_in, // incremented program counter
  input wire logic [7:0] rd_data, // data memory read value
  output logic [11:0] mem_addr, // data memory address
  output logic rd_en, // read strobe in q2
  output logic wr_en, // write strobe in q4
  output logic [7:0] wr_data, // value written back
  output logic pc_load, // pc write strobe in q4
  output logic [20:0] pc_out, // new program counter
  output logic busy, // second cycle of jump
  output logic [1:0] amode_out // addressing mode used
);
  bsbe_pkg::bsbe_state_t state_reg, state_next;
  logic [15:0] ir_reg, ir_next;
  logic [7:0] data_reg, data_next;
  logic [11:0] addr_reg, addr_next;
  logic [20:0] pc_reg, pc_next;
  logic [1:0] amode_reg, amode_next;
  logic [11:0] gen_addr;
  bsbe_pkg::bsbe_amode_t gen_mode;

  // decode helpers
  function automatic logic is_set_bit(input logic [15:0] w);
    is_set_bit = (w[`BSBE_OPC_HI:`BSBE_OPC_LO] == `BSBE_OPC_SET_BIT);
  endfunction : is_set_bit

  function automatic logic is_jump(input logic [15:0] w);
    is_jump = (w[`BSBE_OPC_HI:`BSBE_JOPC_LO] == `BSBE_OPC_JUMP);
  endfunction : is_jump

  function automatic logic [7:0] bit_mask(input logic [2:0] idx);
    bit_mask = 8'h01 << idx;
  endfunction : bit_mask

  // address resolution for the latched operand
  bsbe_addr_gen u_addr (
    .reg_addr(ir_reg[7:0]),
    .bank_bit(ir_reg[`BSBE_BANK_BIT]),
    .ext_set_en(ext_set_en),
    .bank_selector_reg(bank_selector_reg),
    .index_base(index_base),
    .mem_addr(gen_addr),
    .amode(gen_mode)
  );

  // next-state logic across the four phases
  always_comb begin
    state_next = state_reg;
    ir_next = ir_reg;
    data_next = data_reg;
    addr_next = addr_reg;
    pc_next = pc_reg;
    amode_next = amode_reg;
    unique case (state_reg)
      bsbe_pkg::BSBE_IDLE: begin
        if (phase == `BSBE_PH_Q1 && instr_valid) begin
          ir_next = instr;
          if (is_set_bit(instr)) begin
            state_next = bsbe_pkg::BSBE_SET;
          end else if (is_jump(instr)) begin
            state_next = bsbe_pkg::BSBE_JUMP;
          end
        end
      end
      bsbe_pkg::BSBE_SET: begin
        if (phase == `BSBE_PH_Q2) begin
          addr_next = gen_addr;
          amode_next = gen_mode;
        end
        if (phase == `BSBE_PH_Q3) begin
          data_next = rd_data | bit_mask(ir_reg[`BSBE_BIT_HI:`BSBE_BIT_LO]);
        end
        if (phase == `BSBE_PH_Q4) begin
          state_next = bsbe_pkg::BSBE_IDLE;
        end
      end
      bsbe_pkg::BSBE_JUMP: begin
        if (phase == `BSBE_PH_Q3) begin
          // sign-extend the 11-bit offset, doubled; status flags untouched
          pc_next = pc_in + {{9{ir_reg[`BSBE_OFS_HI]}}, ir_reg[`BSBE_OFS_HI:0], 1'b0};
        end
        if (phase == `BSBE_PH_Q4) begin
          state_next = bsbe_pkg::BSBE_DEAD;
        end
      end
      bsbe_pkg::BSBE_DEAD: begin
        // idle cycle: no strobes in any phase; back to idle at q4
        if (phase == `BSBE_PH_Q4) begin
          state_next = bsbe_pkg::BSBE_IDLE;
        end
      end
      default: begin
        state_next = bsbe_pkg::BSBE_IDLE;
      end
    endcase
  end

  // state registers
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= bsbe_pkg::BSBE_IDLE;
      ir_reg <= 16'h0000;
      data_reg <= 8'h00;
      addr_reg <= 12'h000;
      pc_reg <= `BSBE_PC_RESET;
      amode_reg <= 2'h0;
    end else begin
      state_reg <= state_next;
      ir_reg <= ir_next;
      data_reg <= data_next;
      addr_reg <= addr_next;
      pc_reg <= pc_next;
      amode_reg <= amode_next;
    end
  end

  // strobes and data outputs
  assign rd_en = (state_reg == bsbe_pkg::BSBE_SET) && (phase == `BSBE_PH_Q2);
  assign wr_en = (state_reg == bsbe_pkg::BSBE_SET) && (phase == `BSBE_PH_Q4);
  assign pc_load = (state_reg == bsbe_pkg::BSBE_JUMP) && (phase == `BSBE_PH_Q4);
  assign busy = (state_reg == bsbe_pkg::BSBE_DEAD);
  assign mem_addr = (phase == `BSBE_PH_Q2) ? gen_addr : addr_reg;
  assign wr_data = data_reg;
  assign pc_out = pc_reg;
  assign amode_out = amode_reg;
endmodule : bsbe_exec
`default_nettype wire

/* File: core/bsbe_pkg.sv */
/*
  types for the bit-set and relative-jump executor.
  assumes bsbe_consts.svh is available.
*/
package bsbe_pkg;
  typedef enum logic [1:0] {BSBE_IDLE, BSBE_SET, BSBE_JUMP, BSBE_DEAD} bsbe_state_t;
  typedef enum logic [1:0] {BSBE_MODE_ACCESS, BSBE_MODE_BANKED, BSBE_MODE_INDEXED} bsbe_amode_t;
endpackage : bsbe_pkg

/* File: dv/bsbe_exec_props.sv */
/* checker on the bsbe_exec ports.
   assumes it is bound into every bsbe_exec. */
`timescale 1ns/1ps
`default_nettype none
module bsbe_exec_props (
  input wire logic clk_sys, // clk
  input wire logic reset_n, // rst
  input wire logic [1:0] phase, // q code
  input wire logic [15:0] instr, // word
  input wire logic instr_valid, // valid
  input wire logic ext_set_en, // ext
  input wire logic [11:0] index_base, // base
  input wire logic [3:0] bank_selector_reg, // bank
  input wire logic [20:0] pc_in, // pc
  input wire logic [7:0] rd_data, // rd
  input wire logic [11:0] mem_addr, // addr
  input wire logic rd_en, // rd
  input wire logic wr_en, // wr
  input wire logic [7:0] wr_data, // wr
  input wire logic pc_load, // load
  input wire logic [20:0] pc_out, // pc
  input wire logic busy // idle
);
  logic [15:0] ip_reg; // word of the q1 before
  wire logic [2:0] bsel = instr[11:9]; // bit index
  wire logic [20:0] jo = {{9{instr[10]}}, instr[10:0], 1'b0}; // doubled offset
  wire logic [7:0] f = ip_reg[7:0]; // register operand
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // hold the word for the q2 address checks
  always_ff @(posedge clk_sys) ip_reg <= instr;
  // decode, strobe timing, data and address
  a_set_take: assert property (phase == 2'h0 && instr_valid && instr[15:12] == 4'h8 && !busy |=> rd_en ##2 wr_en)
    else $error("bad set");
  a_jump_two: assert property (phase == 2'h0 && instr_valid && instr[15:11] == 5'h1a && !busy |-> ##3 pc_load ##1 busy[*4] ##1 !busy)
    else $error("bad jump");
  a_bit_or: assert property (wr_en |-> wr_data == ($past(rd_data) | (8'h01 << $past(bsel, 3))))
    else $error("bad data");
  a_pc_sum: assert property (pc_load |-> pc_out == $past(pc_in) + $past(jo, 3))
    else $error("bad pc");
  a_idle_quiet: assert property (busy |-> !rd_en && !wr_en && !pc_load)
    else $error("busy active");
  a_bank_sel: assert property (rd_en && ip_reg[8] |-> mem_addr == {bank_selector_reg, f})
    else $error("bad bank");
  a_access_high: assert property (rd_en && !ip_reg[8] && f > 8'h5f |-> mem_addr == {4'hf, f})
    else $error("bad access");
  a_index_low: assert property (rd_en && !ip_reg[8] && ext_set_en && f <= 8'h5f |-> mem_addr == index_base + f)
    else $error("bad index");
endmodule : bsbe_exec_props
bind bsbe_exec bsbe_exec_props i_bsbe_exec_props (.clk_sys, .reset_n, .phase, .instr, .instr_valid, .ext_set_en,
  .index_base, .bank_selector_reg, .pc_in, .rd_data, .mem_addr, .rd_en, .wr_en, .wr_data, .pc_load, .pc_out, .busy);
`default_nettype wire

/* File: dv/bsbe_exec_tb.sv */
/* bench: bit set and jump scenarios on bsbe_exec.
   assumes the checker is bound from bsbe_exec_props.sv. */
`timescale 1ns/1ps
`default_nettype none
module bsbe_exec_tb;
  logic clk_sys = 1'b0, reset_n = 1'b0, instr_valid = 1'b0, ext_set_en = 1'b0;
  logic rd_en, wr_en, pc_load, busy;
  logic [1:0] phase = 2'h0, amode_out;
  logic [3:0] bank_selector_reg = 4'h3;
  logic [7:0] rd_data = 8'h00, wr_data;
  logic [11:0] index_base = 12'h100, mem_addr;
  logic [15:0] instr = 16'h0000;
  logic [20:0] pc_in = 21'h001000, pc_out;
  int fails = 0, checks = 0;
  bsbe_exec i_bsbe_exec (.clk_sys, .reset_n, .phase, .instr, .instr_valid, .ext_set_en, .bank_selector_reg,
    .index_base, .pc_in, .rd_data, .mem_addr, .rd_en, .wr_en, .wr_data, .pc_load, .pc_out, .busy, .amode_out);
  // clock and free-running phase
  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) phase <= #1 phase + 2'h1;
  task chk(input logic [20:0] got, input logic [20:0] exp);
    checks++;
    if (got !== exp) begin
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      fails++;
    end
  endtask : chk
  // offer a word for the next q1, return at start of q2
  task go(input logic [15:0] w);
    do @(posedge clk_sys); while (phase !== 2'h3);
    #1 instr = w;
    instr_valid = 1'b1;
    @(posedge clk_sys);
    #1 instr_valid = 1'b0;
  endtask : go
  task set_bit(input logic [15:0] w, input logic [7:0] rd, input logic [11:0] adr);
    go(w);
    rd_data = rd;
    @(negedge clk_sys);
    chk(rd_en, 1'b1);
    chk(mem_addr, adr);
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    chk(wr_en, 1'b1);
    chk(wr_data, rd | (8'h01 << w[11:9]));
    chk(amode_out, w[8] ? 2'h1 : ((ext_set_en && w[7:0] <= 8'h5f) ? 2'h2 : 2'h0));
  endtask : set_bit
  // jump, then a refused word during the idle cycle
  task jump(input logic [10:0] n, input logic [20:0] pc);
    go({5'h1a, n});
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    chk(pc_load, 1'b1);
    chk(pc_out, pc);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_sys);
      #1 instr_valid = (i == 0);
      @(negedge clk_sys);
      chk(busy, 1'b1);
      chk(rd_en | pc_load, 1'b0);
    end
    @(negedge clk_sys);
    chk(busy, 1'b0);
  endtask : jump
  task final_report;
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : final_report
  initial begin
    repeat (16) @(posedge clk_sys);
    #1 reset_n = 1'b1;
    set_bit(16'h8f12, 8'h0a, 12'h312);
    set_bit(16'h8040, 8'hfe, 12'h040);
    set_bit(16'h8c80, 8'h00, 12'hf80);
    @(posedge clk_sys);
    #1 ext_set_en = 1'b1;
    set_bit(16'h8a5f, 8'h11, 12'h15f);
    set_bit(16'h8660, 8'h80, 12'hf60);
    set_bit(16'h8360, 8'h00, 12'h360);
    jump(11'h7ff, 21'h000ffe);
    jump(11'h400, 21'h000800);
    jump(11'h3ff, 21'h0017fe);
    final_report();
  end
  // watchdog against a hang
  initial begin
    #5000;
    fails++;
    final_report();
  end
endmodule : bsbe_exec_tb
`default_nettype wire
